// ---- logic/ppc_pkg.sv ----
// package: register map, field positions and reset values for the port control bank
// ********************************************************************
// How it works
// - fault count low byte per port is read-only after a cable test
// - fault count bit eight reads read-only in bit zero of preceding register
// - negotiation-disable bit stops negotiation; speed and duplex come from bits 6:5
// - forced speed: one gives 100 megabit, zero gives 10; resets to one
// - duplex bit applies when negotiation off or failed; resets to half
// - LED-off bit of any port drives every port's port_led_off output high
// - transmit-disable bit turns off that port's transmitter
// - writing one to restart bit restarts negotiation; bit self-clears
// - crossover-disable bit turns off automatic straight/crossover detection
// - with detection off, forced-straight bit forces straight pin mode
// ********************************************************************
package ppc_pkg;
  localparam int          NUM_PORTS       = 4;
  localparam logic [7:0]  ADDR_FAULT_HI   = 8'h2A;
  localparam logic [7:0]  ADDR_FAULT_LO   = 8'h2B;
  localparam logic [7:0]  ADDR_FORCED     = 8'h2C;
  localparam logic [7:0]  ADDR_LINE       = 8'h2D;
  localparam logic [7:0]  PORT_STRIDE     = 8'h10;
  localparam int          FM_AN_DIS       = 7;
  localparam int          FM_SPEED        = 6;
  localparam int          FM_DUPLEX       = 5;
  localparam logic [4:0]  FM_RSVD_VAL     = 5'h1F;
  localparam logic [2:0]  FM_RST          = 3'h2;
  localparam int          LC_LED_OFF      = 7;
  localparam int          LC_TX_DIS       = 6;
  localparam int          LC_RESTART      = 5;
  localparam int          LC_PWR_DOWN     = 3;
  localparam int          LC_XOVER_DIS    = 2;
  localparam int          LC_FORCE_STR    = 1;
  localparam logic [7:0]  LC_RST          = 8'h00;
  // restart and reserved bits are not stored, so they always read back zero
  localparam logic [7:0]  LC_WR_MASK      = 8'hCE;
endpackage : ppc_pkg

// ---- logic/ppc_port_phy_control_regs.sv ----
// module: per-port forced-mode and line control registers with cable fault readback
//
// Strobed register access was left to the implementer.
`timescale 1ns/100ps
module ppc_port_phy_control_regs #(
  parameter int NUM_PORTS = ppc_pkg::NUM_PORTS
) (
  input  wire logic                   clk,
  input  wire logic                   reset_n,
  input  wire logic [7:0]             addr,
  input  wire logic [7:0]             wr_data,
  input  wire logic                   wr_stb,
  input  wire logic                   rd_stb,
  output logic      [7:0]             rd_data,
  input  wire logic [NUM_PORTS*9-1:0] cable_fault_distance_count,
  input  wire logic [NUM_PORTS-1:0]   an_failed,
  output logic      [NUM_PORTS-1:0]   an_disable,
  output logic      [NUM_PORTS-1:0]   speed_100,
  output logic      [NUM_PORTS-1:0]   duplex_full,
  output logic      [NUM_PORTS-1:0]   an_restart,
  output logic      [NUM_PORTS-1:0]   tx_disable,
  output logic      [NUM_PORTS-1:0]   power_down,
  output logic      [NUM_PORTS-1:0]   auto_xover_en,
  output logic      [NUM_PORTS-1:0]   force_straight,
  output logic      [NUM_PORTS-1:0]   port_led_off
);
  // ********************************************************************
  // state
  // ********************************************************************
  typedef struct packed {
    logic [NUM_PORTS-1:0][2:0] fm;
    logic [NUM_PORTS-1:0][7:0] lc;
    logic [NUM_PORTS-1:0][8:0] fault;
    logic [NUM_PORTS-1:0]      restart;
    logic [NUM_PORTS-1:0]      an_dis;
    logic [NUM_PORTS-1:0]      spd;
    logic [NUM_PORTS-1:0]      dup;
    logic [NUM_PORTS-1:0]      txd;
    logic [NUM_PORTS-1:0]      pwd;
    logic [NUM_PORTS-1:0]      axe;
    logic [NUM_PORTS-1:0]      fstr;
    logic [NUM_PORTS-1:0]      led;
    logic [7:0]                rdata;
  } ppc_state_t;

  ppc_state_t st_ff;
  ppc_state_t nxt_st;

  // address of a register for a given port, port index from zero
  function automatic logic [7:0] ppc_port_addr(input logic [7:0] base, input int p);
    ppc_port_addr = base + 8'(p) * ppc_pkg::PORT_STRIDE;
  endfunction : ppc_port_addr

  // ********************************************************************
  // next state
  // ********************************************************************
  always_comb begin
    logic [7:0] fm_byte;
    logic       led_all;
    fm_byte = 8'h00;
    led_all = 1'b0;
    nxt_st = st_ff;
    nxt_st.rdata = 8'h00;
    for (int p = 0; p < NUM_PORTS; p++) begin
      // fault count sampled every cycle; the test logic holds it stable after a test
      nxt_st.fault[p] = cable_fault_distance_count[p*9 +: 9];
      nxt_st.restart[p] = 1'b0;
      if (wr_stb && addr == ppc_port_addr(ppc_pkg::ADDR_FORCED, p)) begin
        nxt_st.fm[p] = wr_data[7:5];
      end
      if (wr_stb && addr == ppc_port_addr(ppc_pkg::ADDR_LINE, p)) begin
        // restart bit is never stored, so it always reads back zero
        nxt_st.lc[p] = wr_data & ppc_pkg::LC_WR_MASK;
        nxt_st.restart[p] = wr_data[ppc_pkg::LC_RESTART];
      end
      if (rd_stb) begin
        fm_byte = {st_ff.fm[p], ppc_pkg::FM_RSVD_VAL};
        if (addr == ppc_port_addr(ppc_pkg::ADDR_FAULT_HI, p)) begin
          nxt_st.rdata = {7'h00, st_ff.fault[p][8]};
        end else if (addr == ppc_port_addr(ppc_pkg::ADDR_FAULT_LO, p)) begin
          nxt_st.rdata = st_ff.fault[p][7:0];
        end else if (addr == ppc_port_addr(ppc_pkg::ADDR_FORCED, p)) begin
          nxt_st.rdata = fm_byte;
        end else if (addr == ppc_port_addr(ppc_pkg::ADDR_LINE, p)) begin
          nxt_st.rdata = st_ff.lc[p];
        end
      end
      led_all = led_all | nxt_st.lc[p][ppc_pkg::LC_LED_OFF];
    end
    for (int p = 0; p < NUM_PORTS; p++) begin
      nxt_st.an_dis[p] = nxt_st.fm[p][2];
      nxt_st.spd[p]    = nxt_st.fm[p][1];
      // duplex matters to the phy only when forced or negotiation failed
      nxt_st.dup[p]    = nxt_st.fm[p][0] & (nxt_st.fm[p][2] | an_failed[p]);
      nxt_st.txd[p]    = nxt_st.lc[p][ppc_pkg::LC_TX_DIS];
      nxt_st.pwd[p]    = nxt_st.lc[p][ppc_pkg::LC_PWR_DOWN];
      nxt_st.axe[p]    = ~nxt_st.lc[p][ppc_pkg::LC_XOVER_DIS];
      nxt_st.fstr[p]   = nxt_st.lc[p][ppc_pkg::LC_XOVER_DIS]
                         & nxt_st.lc[p][ppc_pkg::LC_FORCE_STR];
      nxt_st.led[p]    = led_all;
    end
  end

  // ********************************************************************
  // registers
  // ********************************************************************
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      st_ff <= '0;
      for (int p = 0; p < NUM_PORTS; p++) begin
        st_ff.fm[p]  <= ppc_pkg::FM_RST;
        st_ff.lc[p]  <= ppc_pkg::LC_RST;
        st_ff.spd[p] <= 1'b1;
        st_ff.axe[p] <= 1'b1;
      end
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign rd_data        = st_ff.rdata;
  assign an_disable     = st_ff.an_dis;
  assign speed_100      = st_ff.spd;
  assign duplex_full    = st_ff.dup;
  assign an_restart     = st_ff.restart;
  assign tx_disable     = st_ff.txd;
  assign power_down     = st_ff.pwd;
  assign auto_xover_en  = st_ff.axe;
  assign force_straight = st_ff.fstr;
  assign port_led_off   = st_ff.led;
endmodule : ppc_port_phy_control_regs

// ---- test/ppc_regs_properties.sv ----
// checker: port control bank assertions
`timescale 1ns/100ps
module ppc_regs_properties #(parameter int NUM_PORTS = 4) (
  input wire logic                 clk, reset_n, wr_stb, rd_stb,
  input wire logic [7:0]           addr, wr_data, rd_data,
  input wire logic [NUM_PORTS-1:0] an_failed, an_disable, speed_100, duplex_full, an_restart,
  input wire logic [NUM_PORTS-1:0] tx_disable, auto_xover_en, force_straight, port_led_off
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  sequence line_wr; wr_stb && addr == 8'h2D; endsequence
  sequence restart_pulse; an_restart[0] ##1 !an_restart[0]; endsequence
  forced_mode_a:
    assert property (wr_stb && addr == 8'h2C |=> an_disable[0] == $past(wr_data[7])
      && speed_100[0] == $past(wr_data[6])) else $error("forced mode mismatch");
  duplex_src_a:
    assert property (duplex_full[0] |-> an_disable[0] || an_failed[0] || $past(an_failed[0]))
      else $error("duplex forced without cause");
  reserved_a:
    assert property (rd_stb && addr == 8'h2C |=> rd_data[4:0] == 5'h1F) else $error("reserved");
  led_off_a:
    assert property (line_wr ##0 wr_data[7] |=> port_led_off == 4'hF) else $error("led off");
  tx_off_a:
    assert property (line_wr |=> tx_disable[0] == $past(wr_data[6])) else $error("tx disable");
  restart_a:
    assert property (line_wr ##0 wr_data[5] |=> restart_pulse) else $error("restart pulse");
  xover_a:
    assert property (line_wr |=> auto_xover_en[0] == !$past(wr_data[2])) else $error("xover");
  straight_a:
    assert property (force_straight[0] |-> !auto_xover_en[0]) else $error("straight");
  port_iso_a:
    assert property (wr_stb && addr == 8'h3D |=> $stable(tx_disable[0])) else $error("port leak");
  unmapped_a:
    assert property (rd_stb && addr == 8'h2E |=> rd_data == 8'h00) else $error("unmapped read");
endmodule : ppc_regs_properties
bind ppc_port_phy_control_regs ppc_regs_properties #(.NUM_PORTS(NUM_PORTS)) u_props (.*);

// ---- test/ppc_port_phy_control_regs_tb.sv ----
// testbench: port control bank scenarios
`timescale 1ns/100ps
module ppc_port_phy_control_regs_tb;
  logic        clk = 0, reset_n = 0, wr_stb = 0, rd_stb = 0;
  logic [7:0]  addr = 8'h00, wr_data = 8'h00, rd_data;
  logic [35:0] cable_fault_distance_count = '0;
  logic [3:0]  an_failed = 4'h0, an_disable, speed_100, duplex_full, an_restart, tx_disable;
  logic [3:0]  power_down, auto_xover_en, force_straight, port_led_off;
  int          miscompares = 0, compares = 0;
  ppc_port_phy_control_regs dut (.*);
  initial forever #5 clk = ~clk;
  task chk(string n, logic [7:0] seen, logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", n, exp, seen);
    end
  endtask : chk
  // one-cycle strobes; outputs looked at once the update edge has landed
  task wr(logic [7:0] a, logic [7:0] d);
    @(posedge clk);
    {wr_stb, addr, wr_data} <= {1'b1, a, d};
    @(posedge clk);
    wr_stb <= 0;
    @(posedge clk) #1;
  endtask : wr
  task rd(logic [7:0] a, logic [7:0] exp);
    @(posedge clk);
    {rd_stb, addr} <= {1'b1, a};
    @(posedge clk);
    rd_stb <= 0;
    #1 chk("rd_data", rd_data, exp);
  endtask : rd
  task t_reset;
    chk("reset_out", {speed_100, auto_xover_en}, 8'hFF);
    chk("reset_low", {duplex_full, an_disable}, 8'h00);
    for (int p = 0; p < 4; p++) begin
      rd(8'h2C + 8'(p * 16), 8'h5F);
      rd(8'h2D + 8'(p * 16), 8'h00);
    end
  endtask : t_reset
  task t_forced;
    // negotiation-disable is only ever set on port 1, never on port 4
    wr(8'h2C, 8'hE0);
    chk("forced", {5'h00, an_disable[0], speed_100[0], duplex_full[0]}, 8'h07);
    rd(8'h2C, 8'hFF);
    wr(8'h2C, 8'h80);
    chk("forced_10", {5'h00, an_disable[0], speed_100[0], duplex_full[0]}, 8'h04);
    wr(8'h2C, 8'h20);
    chk("an_ok", {7'h00, duplex_full[0]}, 8'h00);
    an_failed <= 4'h1;
    repeat (2) @(posedge clk);
    #1 chk("an_failed", {7'h00, duplex_full[0]}, 8'h01);
    an_failed <= 4'h0;
  endtask : t_forced
  task t_line;
    wr(8'h2D, 8'hEE);
    chk("line", {tx_disable[0], power_down[0], auto_xover_en[0], force_straight[0], port_led_off}, 8'hDF);
    chk("port2", {4'h0, tx_disable[1], power_down[1], auto_xover_en[1], force_straight[1]}, 8'h02);
    rd(8'h2D, 8'hCE);
    wr(8'h3D, 8'h02);
    chk("no_force", {5'h00, auto_xover_en[1], force_straight[1], tx_disable[0]}, 8'h05);
    wr(8'h2D, 8'h00);
    chk("line_clr", {2'h0, port_led_off, force_straight[0], auto_xover_en[0]}, 8'h01);
  endtask : t_line
  task t_fault;
    cable_fault_distance_count <= {9'h0FF, 9'h000, 9'h1A5, 9'h000};
    rd(8'h3A, 8'h01);
    rd(8'h3B, 8'hA5);
    wr(8'h3B, 8'h00);
    rd(8'h3B, 8'hA5);
    rd(8'h5B, 8'hFF);
    rd(8'h2E, 8'h00);
  endtask : t_fault
  task wrap_up;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : wrap_up
  initial begin
    repeat (20) @(posedge clk);
    reset_n <= 1;
    t_reset;
    t_forced;
    t_line;
    t_fault;
    wrap_up;
  end
endmodule : ppc_port_phy_control_regs_tb
